// File: hw/scl_pkg.sv
// Purpose: shared constants and types for the serial config loader
// Assumes: 25 MHz system clock on both ends
// Notes: times are kept in their own unit, cycles derived from them
package scl_pkg;
  // ----------------------------------------
  // clock and timing
  // ----------------------------------------
  localparam int CLK_NS = 40;
  localparam int MIN_GAP_NS = 100;
  localparam int MIN_GAP_CYC = (MIN_GAP_NS + CLK_NS - 1) / CLK_NS;
  localparam int WAKE_US = 1000;
  localparam int WAKE_CYC = WAKE_US * 1000 / CLK_NS;
  localparam int WATCH_US = 5000;
  localparam int WATCH_CYC = WATCH_US * 1000 / CLK_NS;
  localparam int SLEEP_US = 10000;
  localparam int SLEEP_CYC = SLEEP_US * 1000 / CLK_NS;
  localparam int LISTEN_US = 2000;
  localparam int LISTEN_CYC = LISTEN_US * 1000 / CLK_NS;
  localparam int TMR_W = 18;
  // ----------------------------------------
  // configuration word
  // ----------------------------------------
  localparam int CFG_W = 20;
  localparam int CNT_W = 5;
  localparam int BIT_BW_SELECT_FIRST = 3;
  localparam int BIT_BW_SELECT_SECOND = 4;
  localparam int BIT_POLL = 15;
  localparam int BIT_FAST = 16;
  localparam int BIT_GUARD = 18;
  localparam logic [CFG_W-1:0] CFG_RESET = 20'h00000;
  localparam int BW_W = 14;
  localparam logic [BW_W-1:0] BW_HZ_SS = 14'h06B0;
  localparam logic [BW_W-1:0] BW_HZ_OS = 14'h0D61;
  localparam logic [BW_W-1:0] BW_HZ_SO = 14'h1AC2;
  localparam logic [BW_W-1:0] BW_HZ_OO = 14'h3584;
  // ----------------------------------------
  // controller registers
  // ----------------------------------------
  localparam int ADDR_W = 4;
  localparam logic [ADDR_W-1:0] REG_CTRL = 4'h0;
  localparam logic [ADDR_W-1:0] REG_DATA = 4'h4;
  localparam logic [ADDR_W-1:0] REG_GO = 4'h8;
  localparam logic [ADDR_W-1:0] REG_STAT = 4'hC;
  localparam int CTRL_W = 4;
  localparam int CTRL_PD = 0;
  localparam int CTRL_BW_SELECT_FIRST = 1;
  localparam int CTRL_BW_SELECT_SECOND = 2;
  localparam int CTRL_NG = 3;
  localparam logic [CTRL_W-1:0] CTRL_RESET = 4'hF;
  localparam int STAT_BUSY = 0;
  localparam int STAT_DO = 1;
  // ----------------------------------------
  // state types
  // ----------------------------------------
  typedef enum logic [2:0] {
    DEV_IDLE = 3'h0, DEV_RELEASED = 3'h1, DEV_START_LO = 3'h2, DEV_START_HI = 3'h3,
    DEV_START_MK = 3'h4, DEV_SHIFT = 3'h5, DEV_STOP_HI = 3'h6, DEV_STOP_LO = 3'h7
  } scl_dev_state_type;
  typedef enum logic [1:0] {
    POLL_OFF = 2'h0, POLL_SLEEP = 2'h1, POLL_LISTEN = 2'h2, POLL_WOKEN = 2'h3
  } scl_poll_state_type;
  typedef enum logic [3:0] {
    H_IDLE = 4'h0, H_CKHI = 4'h1, H_DRV = 4'h2, H_CKLO = 4'h3, H_CKHI2 = 4'h4,
    H_MKHI = 4'h5, H_MKLO = 4'h6, H_BLO = 4'h7, H_BHI = 4'h8, H_PLO = 4'h9,
    H_PHI = 4'hA, H_PDHI = 4'hB, H_PDLO = 4'hC, H_END = 4'hD
  } scl_host_state_type;
endpackage

// File: hw/scl_link_if.sv
// Purpose: pins between the receiver end and the controller end
// Assumes: data line sinks low when nobody drives it
// Notes: only this interface resolves the shared data line
`timescale 1ns/10ps
interface scl_link_if;
  logic sclk;
  logic power_down_pin;
  logic bw_select_first;
  logic bw_select_second;
  logic noise_gate_input;
  logic dev_do;
  logic dev_do_oe;
  logic host_do;
  logic host_do_oe;
  logic do_line;
  // ----------------------------------------
  // shared data line
  // ----------------------------------------
  assign do_line = dev_do_oe ? dev_do : (host_do_oe ? host_do : 1'h0);
  modport dev (
    input sclk, power_down_pin, bw_select_first, bw_select_second, do_line,
    output dev_do, dev_do_oe
  );
  modport host (
    output sclk, power_down_pin, bw_select_first, bw_select_second, noise_gate_input,
    output host_do, host_do_oe,
    input do_line
  );
endinterface

// File: hw/scl_host.sv
// Purpose: controller end, drives clock and data to load the config word
// Assumes: software uses the plain register port
// Notes: every pin phase lasts MIN_GAP_CYC cycles
`timescale 1ns/10ps
module scl_host
  import scl_pkg::*;
(
  input logic mclk,
  input logic rstn,
  scl_link_if.host link,
  input logic [ADDR_W-1:0] addr,
  input logic [31:0] wdata,
  input logic wr,
  input logic rd,
  output logic [31:0] rdata
);
  scl_host_state_type st;
  logic [CTRL_W-1:0] ctrl;
  logic [CFG_W-1:0] data;
  logic [CNT_W-1:0] idx;
  logic [CNT_W-1:0] pcnt;
  logic tick;
  logic busy;
  logic [1:0] do_sync;
  logic go;
  // ----------------------------------------
  // register port
  // ----------------------------------------
  assign busy = (st != H_IDLE);
  assign go = wr && (addr == REG_GO) && !busy && (wdata < 32'(CFG_W));
  always_ff @(posedge mclk) begin
    if (!rstn) begin
      ctrl <= CTRL_RESET;
    end else if (wr && addr == REG_CTRL) begin
      ctrl <= wdata[CTRL_W-1:0];
    end
  end
  always_ff @(posedge mclk) begin
    if (!rstn) begin
      data <= CFG_RESET;
    end else if (wr && addr == REG_DATA) begin
      data <= wdata[CFG_W-1:0];
    end
  end
  always_ff @(posedge mclk) begin
    if (!rstn) begin
      rdata <= 32'h00000000;
    end else if (rd) begin
      if (addr == REG_CTRL) begin
        rdata <= {28'h0000000, ctrl};
      end else if (addr == REG_DATA) begin
        rdata <= {12'h000, data};
      end else if (addr == REG_STAT) begin
        rdata <= {30'h0, do_sync[1], busy};
      end else begin
        rdata <= 32'h00000000;
      end
    end else begin
      rdata <= 32'h00000000;
    end
  end
  always_ff @(posedge mclk) begin
    if (!rstn) begin
      do_sync <= 2'h0;
    end else begin
      do_sync <= {do_sync[0], link.do_line};
    end
  end
  // ----------------------------------------
  // phase divider
  // ----------------------------------------
  assign tick = (pcnt == CNT_W'(MIN_GAP_CYC - 1));
  always_ff @(posedge mclk) begin
    if (!rstn || st == H_IDLE || tick) begin
      pcnt <= '0;
    end else begin
      pcnt <= pcnt + 1'h1; // [RULE13]
    end
  end
  // ----------------------------------------
  // sequencer
  // ----------------------------------------
  always_ff @(posedge mclk) begin
    if (!rstn) begin
      st <= H_IDLE;
      idx <= '0;
    end else if (st == H_IDLE) begin
      if (go) begin
        st <= H_CKHI;
        idx <= wdata[CNT_W-1:0]; // [RULE10]
      end
    end else if (tick) begin
      case (st)
        H_CKHI: st <= H_DRV;
        H_DRV: st <= H_CKLO; // [RULE7]
        H_CKLO: st <= H_CKHI2;
        H_CKHI2: st <= H_MKHI;
        H_MKHI: st <= H_MKLO; // [RULE8]
        H_MKLO: st <= H_BLO;
        H_BLO: st <= H_BHI;
        H_BHI: begin
          if (idx == '0) begin
            st <= H_PLO;
          end else begin
            idx <= idx - 1'h1; // [RULE9]
            st <= H_BLO;
          end
        end
        H_PLO: st <= H_PHI;
        H_PHI: st <= H_PDHI;
        H_PDHI: st <= H_PDLO; // [RULE11]
        H_PDLO: st <= H_END;
        default: st <= H_IDLE;
      endcase
    end
  end
  // ----------------------------------------
  // pins
  // ----------------------------------------
  always_ff @(posedge mclk) begin
    if (!rstn) begin
      link.sclk <= 1'h0;
      link.host_do <= 1'h0;
      link.host_do_oe <= 1'h0;
    end else begin
      link.sclk <= (st == H_CKHI) || (st == H_DRV) || (st == H_CKHI2) || (st == H_MKHI)
                   || (st == H_MKLO) || (st == H_BHI) || (st == H_PHI) || (st == H_PDHI)
                   || (st == H_PDLO) || (st == H_PLO); // [RULE15] [RULE9]
      link.host_do_oe <= (st != H_IDLE) && (st != H_CKHI) && (st != H_END);
      if (st == H_BLO || st == H_BHI) begin
        link.host_do <= data[idx]; // [RULE9]
      end else begin
        link.host_do <= (st == H_MKHI) || (st == H_PDHI); // [RULE8] [RULE11]
      end
    end
  end
  always_ff @(posedge mclk) begin
    if (!rstn) begin
      link.power_down_pin <= 1'h1;
      link.bw_select_first <= 1'h1;
      link.bw_select_second <= 1'h1;
      link.noise_gate_input <= 1'h1;
    end else begin
      link.power_down_pin <= ctrl[CTRL_PD];
      link.bw_select_first <= ctrl[CTRL_BW_SELECT_FIRST]; // [RULE14]
      link.bw_select_second <= ctrl[CTRL_BW_SELECT_SECOND];
      link.noise_gate_input <= ctrl[CTRL_NG];
    end
  end
endmodule

// File: hw/scl_dev.sv
// Purpose: receiver end, loads a 20-bit mode word over the two-wire link
// Assumes: rx_data and rx_hit come from demodulator logic on mclk
// Notes: all link pins pass two flip-flops before use
//
// The implementer's own choices: the register addresses and the strobed register port.
`timescale 1ns/10ps
// What this block does
// RULE1: bandwidth from straps and serial bits 3,4
// RULE2: bit 16 high selects fast bandwidth
// RULE3: data pin becomes serial input while programming
// RULE4: power-down high stops operation
// RULE5: data appears about 1 ms after power-up
// RULE6: clock high releases the data pin
// RULE7: controller drives data low after release
// RULE8: start: clock low-high, data pulse while high
// RULE9: bits shifted most significant first
// RULE10: partial write from any bit down to 0
// RULE11: stop: data pulse while clock high, clock low
// RULE12: stop ends programming, data pin drives again
// RULE13: all phases longer than 0.1 us
// RULE14: controller holds selects and noise gate high; the host drives them from REG_CTRL bits, reset high, which software can clear
// RULE15: controller keeps clock low when idle
// RULE16: autopoll wakes by data pin starting to toggle
// RULE17: bit 15 high enables autopoll
// RULE18: bit 18 high disables poll watchdog
// RULE19: sample data on each clock rise
// RULE20: apply only on stop, keep unsent bits
module scl_dev
  import scl_pkg::*;
#(
  parameter int WAKE_CYCLES = WAKE_CYC,
  parameter int SLEEP_CYCLES = SLEEP_CYC,
  parameter int LISTEN_CYCLES = LISTEN_CYC,
  parameter int WATCH_CYCLES = WATCH_CYC
)
(
  input logic mclk,
  input logic rstn,
  scl_link_if.dev link,
  input logic rx_data,
  input logic rx_hit,
  output logic [CFG_W-1:0] cfg,
  output logic [BW_W-1:0] bw_hz,
  output logic fast_bw,
  output logic rx_enable,
  output logic prog_active
);
  scl_dev_state_type st;
  scl_dev_state_type next_st;
  scl_poll_state_type pst;
  logic [4:0] meta;
  logic [4:0] sync;
  logic s_clk;
  logic s_do;
  logic s_pd;
  logic clk_prev;
  logic do_prev;
  logic clk_rise;
  logic clk_fall;
  logic do_rise;
  logic do_fall;
  logic [CFG_W-1:0] shreg;
  logic [CNT_W-1:0] nbits;
  logic [CFG_W-1:0] mask;
  logic apply;
  logic [TMR_W-1:0] wcnt;
  logic awake;
  logic [TMR_W-1:0] tcnt;
  logic [1:0] sel;
  logic listening;
  // ----------------------------------------
  // pin synchronisers and edges
  // ----------------------------------------
  always_ff @(posedge mclk) begin
    if (!rstn) begin
      meta <= 5'h04;
      sync <= 5'h04;
    end else begin
      meta <= {link.bw_select_second, link.bw_select_first, link.power_down_pin,
               link.do_line, link.sclk};
      sync <= meta;
    end
  end
  assign s_clk = sync[0];
  assign s_do = sync[1];
  assign s_pd = sync[2];
  always_ff @(posedge mclk) begin
    if (!rstn) begin
      clk_prev <= 1'h0;
      do_prev <= 1'h0;
    end else begin
      clk_prev <= s_clk;
      do_prev <= s_do;
    end
  end
  assign clk_rise = s_clk && !clk_prev;
  assign clk_fall = !s_clk && clk_prev;
  assign do_rise = s_do && !do_prev && s_clk && clk_prev;
  assign do_fall = !s_do && do_prev && s_clk && clk_prev;
  // ----------------------------------------
  // link sequence tracker
  // ----------------------------------------
  always_comb begin
    next_st = st;
    case (st)
      DEV_IDLE: begin
        if (s_clk) begin
          next_st = DEV_RELEASED; // [RULE6]
        end
      end
      DEV_RELEASED: begin
        if (clk_fall) begin
          next_st = s_do ? DEV_IDLE : DEV_START_LO; // [RULE8]
        end
      end
      DEV_START_LO: begin
        if (clk_rise) begin
          next_st = s_do ? DEV_IDLE : DEV_START_HI; // [RULE8]
        end
      end
      DEV_START_HI: begin
        if (do_rise) begin
          next_st = DEV_START_MK;
        end else if (clk_fall) begin
          next_st = DEV_IDLE;
        end
      end
      DEV_START_MK: begin
        if (do_fall) begin
          next_st = DEV_SHIFT; // [RULE8]
        end else if (clk_fall) begin
          next_st = DEV_IDLE;
        end
      end
      DEV_SHIFT: begin
        if (do_rise) begin
          next_st = DEV_STOP_HI;
        end
      end
      DEV_STOP_HI: begin
        if (do_fall) begin
          next_st = DEV_STOP_LO;
        end else if (clk_fall) begin
          next_st = DEV_IDLE;
        end
      end
      DEV_STOP_LO: begin
        if (clk_fall) begin
          next_st = DEV_IDLE; // [RULE12]
        end
      end
      default: next_st = DEV_IDLE;
    endcase
  end
  always_ff @(posedge mclk) begin
    if (!rstn || s_pd) begin
      st <= DEV_IDLE;
    end else begin
      st <= next_st;
    end
  end
  assign apply = (st == DEV_STOP_LO) && clk_fall;
  assign prog_active = (st != DEV_IDLE);
  // ----------------------------------------
  // shift register and load
  // ----------------------------------------
  always_ff @(posedge mclk) begin
    if (!rstn) begin
      shreg <= CFG_RESET;
      nbits <= '0;
    end else if (st == DEV_START_MK && do_fall) begin
      nbits <= '0;
    end else if (st == DEV_SHIFT && clk_rise) begin
      shreg <= {shreg[CFG_W-2:0], s_do}; // [RULE19] [RULE9] [RULE3]
      if (nbits != CNT_W'(CFG_W)) begin
        nbits <= nbits + 1'h1;
      end
    end
  end
  genvar gi;
  generate
    for (gi = 0; gi < CFG_W; gi = gi + 1) begin : g_mask
      assign mask[gi] = (nbits > CNT_W'(gi)); // [RULE10]
    end
  endgenerate
  always_ff @(posedge mclk) begin
    if (!rstn) begin
      cfg <= CFG_RESET;
    end else if (apply) begin
      cfg <= (cfg & ~mask) | (shreg & mask); // [RULE20]
    end
  end
  // ----------------------------------------
  // bandwidth selection
  // ----------------------------------------
  assign sel = {sync[4] & cfg[BIT_BW_SELECT_SECOND], sync[3] & cfg[BIT_BW_SELECT_FIRST]};
  always_ff @(posedge mclk) begin
    if (!rstn) begin
      bw_hz <= BW_HZ_SS;
      fast_bw <= 1'h0;
    end else begin
      case (sel)
        2'h0: bw_hz <= BW_HZ_SS; // [RULE1]
        2'h1: bw_hz <= BW_HZ_OS;
        2'h2: bw_hz <= BW_HZ_SO;
        default: bw_hz <= BW_HZ_OO;
      endcase
      fast_bw <= cfg[BIT_FAST]; // [RULE2]
    end
  end
  // ----------------------------------------
  // power-down and start-up
  // ----------------------------------------
  always_ff @(posedge mclk) begin
    if (!rstn || s_pd) begin
      wcnt <= '0;
      awake <= 1'h0; // [RULE4]
    end else if (!awake) begin
      if (wcnt == TMR_W'(WAKE_CYCLES - 1)) begin
        awake <= 1'h1; // [RULE5]
      end else begin
        wcnt <= wcnt + 1'h1;
      end
    end
  end
  // ----------------------------------------
  // autopoll
  // ----------------------------------------
  always_ff @(posedge mclk) begin
    if (!rstn || !awake || !cfg[BIT_POLL]) begin
      pst <= POLL_OFF; // [RULE17]
      tcnt <= '0;
    end else begin
      case (pst)
        POLL_OFF: begin
          pst <= POLL_SLEEP; // [RULE17]
          tcnt <= '0;
        end
        POLL_SLEEP: begin
          if (tcnt == TMR_W'(SLEEP_CYCLES - 1)) begin
            pst <= POLL_LISTEN;
            tcnt <= '0;
          end else begin
            tcnt <= tcnt + 1'h1;
          end
        end
        POLL_LISTEN: begin
          if (rx_hit) begin
            pst <= POLL_WOKEN; // [RULE16]
            tcnt <= '0;
          end else if (tcnt == TMR_W'(LISTEN_CYCLES - 1)) begin
            pst <= POLL_SLEEP;
            tcnt <= '0;
          end else begin
            tcnt <= tcnt + 1'h1;
          end
        end
        default: begin
          if (rx_hit) begin
            tcnt <= '0;
          end else if (!cfg[BIT_GUARD] && tcnt == TMR_W'(WATCH_CYCLES - 1)) begin
            pst <= POLL_SLEEP; // [RULE18]
            tcnt <= '0;
          end else if (!cfg[BIT_GUARD]) begin
            tcnt <= tcnt + 1'h1;
          end
        end
      endcase
    end
  end
  assign rx_enable = awake && (pst != POLL_SLEEP);
  assign listening = awake && (pst == POLL_OFF || pst == POLL_WOKEN);
  // ----------------------------------------
  // data pin
  // ----------------------------------------
  always_ff @(posedge mclk) begin
    if (!rstn) begin
      link.dev_do <= 1'h0;
    end else begin
      link.dev_do <= listening && rx_data; // [RULE16] [RULE4]
    end
  end
  assign link.dev_do_oe = (st == DEV_IDLE) && !s_clk; // [RULE6] [RULE12] [RULE3]
endmodule

// File: sim/scl_props.sv
// Purpose: concurrent checks on the pins of the two-wire config link
// Assumes: one clock domain, mclk with sync active-low rstn
// Notes: sees the interface signals only
`timescale 1ns/10ps
module scl_props (
  input wire logic mclk,
  input wire logic rstn,
  input wire logic sclk,
  input wire logic power_down_pin,
  input wire logic dev_do,
  input wire logic dev_do_oe,
  input wire logic host_do,
  input wire logic host_do_oe
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rstn);
  // ----------------------------------------
  // marker pulse while clock high
  // ----------------------------------------
  sequence s_mark_rise;
    sclk && host_do_oe && $rose(host_do);
  endsequence
  sequence s_mark_body;
    (sclk && host_do) [*3] ##1 (sclk && !host_do) [*3];
  endsequence
  // ----------------------------------------
  // assertions
  // ----------------------------------------
  a_release_on_clk: assert property ($rose(sclk) |-> ##[0:3] !dev_do_oe)
    else $error("data pin not released after clock rise");
  a_no_fight: assert property (!(dev_do_oe && host_do_oe))
    else $error("both ends drive the data line");
  a_first_drive_low: assert property ($rose(host_do_oe) |-> sclk && !host_do)
    else $error("first drive of data line not low");
  a_marker_shape: assert property (s_mark_rise |-> s_mark_body)
    else $error("marker pulse malformed");
  a_clk_high_len: assert property ($rose(sclk) |-> sclk [*3])
    else $error("clock high phase too short");
  a_clk_low_len: assert property ($fell(sclk) |-> !sclk [*3])
    else $error("clock low phase too short");
  a_idle_clk_low: assert property ($fell(host_do_oe) |-> ##[0:3] !sclk [*3])
    else $error("clock not low after transfer");
  a_drive_returns: assert property ($fell(host_do_oe) |-> ##[1:10] dev_do_oe)
    else $error("data pin not driven again after stop");
  a_down_quiet: assert property (power_down_pin [*5] |-> !dev_do)
    else $error("data out active while powered down");
endmodule

// File: sim/testbench.sv
// Purpose: self-checking bench, controller end joined to receiver end
// Assumes: short wake and poll counts set at the receiver instance
// Notes: random words from a fixed seed
`timescale 1ns/10ps
module testbench;
  import scl_pkg::*;
  localparam int WAKE = 20;
  localparam int SLEEP = 40;
  localparam int LISTEN = 30;
  localparam int WATCH = 30;
  logic mclk = 1'b0;
  logic rstn = 1'b0;
  logic [ADDR_W-1:0] addr = '0;
  logic [31:0] wdata = '0;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic rx_data = 1'b0;
  logic rx_hit = 1'b0;
  logic [31:0] rdata;
  logic [31:0] rv;
  logic [CFG_W-1:0] cfg;
  logic [CFG_W-1:0] model = CFG_RESET;
  logic [CFG_W-1:0] w;
  logic [BW_W-1:0] bw_hz;
  logic [1:0] straps = 2'h3;
  logic fast_bw;
  logic rx_enable;
  logic prog_active;
  int n_errors = 0;
  int check_count = 0;
  int cycles = 0;
  int t;
  int tops[4] = '{0, 2, 17, 5};
  integer seed = 32'hC91FD855;
  scl_link_if scl_link_if_inst ();
  scl_dev #(.WAKE_CYCLES(WAKE), .SLEEP_CYCLES(SLEEP), .LISTEN_CYCLES(LISTEN),
    .WATCH_CYCLES(WATCH)) scl_dev_inst (.mclk(mclk), .rstn(rstn),
    .link(scl_link_if_inst.dev), .rx_data(rx_data), .rx_hit(rx_hit), .cfg(cfg),
    .bw_hz(bw_hz), .fast_bw(fast_bw), .rx_enable(rx_enable), .prog_active(prog_active));
  scl_host scl_host_inst (.mclk(mclk), .rstn(rstn), .link(scl_link_if_inst.host),
    .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata));
  scl_props scl_props_inst (.mclk(mclk), .rstn(rstn), .sclk(scl_link_if_inst.sclk),
    .power_down_pin(scl_link_if_inst.power_down_pin), .dev_do(scl_link_if_inst.dev_do),
    .dev_do_oe(scl_link_if_inst.dev_do_oe), .host_do(scl_link_if_inst.host_do),
    .host_do_oe(scl_link_if_inst.host_do_oe));
  always #20 mclk = ~mclk;
  // ----------------------------------------
  // helpers
  // ----------------------------------------
  task automatic conclude();
    $display("checks %0d mismatches %0d", check_count, n_errors);
    if (n_errors == 0 && check_count > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  always @(posedge mclk) begin
    cycles++;
    if (cycles == 30000) begin
      n_errors++;
      $display("CHECK FAILED at %0t: run timed out", $time);
      conclude();
    end
  end
  task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
    check_count++;
    if (got !== exp) begin
      n_errors++;
      $display("CHECK FAILED at %0t: %s got %h exp %h", $time, what, got, exp);
    end
  endtask
  task automatic reg_wr(input logic [ADDR_W-1:0] a, input logic [31:0] d);
    @(posedge mclk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge mclk);
    wr <= 1'b0;
  endtask
  task automatic reg_rd(input logic [ADDR_W-1:0] a, output logic [31:0] d);
    @(posedge mclk);
    addr <= a;
    rd <= 1'b1;
    @(posedge mclk);
    rd <= 1'b0;
    @(negedge mclk);
    d = rdata;
  endtask
  function automatic logic [BW_W-1:0] exp_bw(input logic [1:0] s, input logic [CFG_W-1:0] c);
    case ({s[1] & c[BIT_BW_SELECT_SECOND], s[0] & c[BIT_BW_SELECT_FIRST]})
      2'h0: return BW_HZ_SS;
      2'h1: return BW_HZ_OS;
      2'h2: return BW_HZ_SO;
      default: return BW_HZ_OO;
    endcase
  endfunction
  task automatic load(input logic [CFG_W-1:0] v, input int top);
    logic [CFG_W-1:0] m;
    int n;
    m = CFG_W'((64'h1 << (top + 1)) - 1);
    model = (model & ~m) | (v & m);
    reg_wr(REG_DATA, 32'(v));
    reg_wr(REG_GO, 32'(top));
    repeat (8) @(posedge mclk);
    @(negedge mclk);
    check(32'(prog_active), 32'h1, "programming entered");
    n = 0;
    rv = 32'h1;
    while (rv[STAT_BUSY] !== 1'b0 && n < 200) begin
      reg_rd(REG_STAT, rv);
      n++;
    end
    repeat (8) @(posedge mclk);
    @(negedge mclk);
    check(32'(n < 200), 32'h1, "transfer end");
    check(32'(cfg), 32'(model), "config word");
    check(32'(fast_bw), 32'(model[BIT_FAST]), "fast bandwidth");
    check(32'(bw_hz), 32'(exp_bw(straps, model)), "bandwidth");
    check(32'(scl_link_if_inst.dev_do_oe), 32'h1, "pin driven again");
    check(32'(prog_active), 32'h0, "programming left");
  endtask
  task automatic toggles(input int n, output int cnt);
    logic last;
    cnt = 0;
    @(negedge mclk);
    last = scl_link_if_inst.dev_do;
    repeat (n) begin
      @(posedge mclk);
      rx_data <= 1'($random(seed));
      @(negedge mclk);
      if (scl_link_if_inst.dev_do !== last) cnt++;
      last = scl_link_if_inst.dev_do;
    end
  endtask
  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    repeat (6) @(posedge mclk);
    rstn <= 1'b1;
    reg_rd(REG_CTRL, rv);
    check(rv, 32'(CTRL_RESET), "control reset");
    check(32'(cfg), 32'(CFG_RESET), "config reset");
    check(32'(bw_hz), 32'(BW_HZ_SS), "bandwidth reset");
    check(32'(scl_link_if_inst.power_down_pin), 32'h1, "down pin reset");
    check(32'(rx_enable), 32'h0, "off while down");
    reg_wr(REG_CTRL, 32'hE);
    t = 0;
    while (rx_enable !== 1'b1 && t < WAKE + 20) begin
      @(negedge mclk);
      t++;
    end
    check(32'(t >= WAKE - 2 && t < WAKE + 20), 32'h1, "wake delay");
    toggles(40, t);
    check(32'(t > 0), 32'h1, "data follows receiver");
    $display("test power up done");
    for (int i = 0; i < 8; i++) begin
      w = i == 0 ? 20'h00000 : i == 1 ? 20'hFFFFF : i == 2 ? 20'hC0000 : 20'($random(seed));
      load(w, 19);
    end
    foreach (tops[k]) load(20'($random(seed)), tops[k]);
    $display("test loads done");
    load(20'h00018, 19);
    for (int s = 0; s < 4; s++) begin
      reg_wr(REG_CTRL, 32'({1'b1, 2'(s), 1'b0}));
      straps = 2'(s);
      repeat (8) @(posedge mclk);
      @(negedge mclk);
      check(32'(scl_link_if_inst.bw_select_first), 32'(straps[0]), "strap pin");
      check(32'(bw_hz), 32'(exp_bw(straps, model)), "strap bandwidth");
    end
    reg_wr(REG_CTRL, 32'hF);
    repeat (8) @(posedge mclk);
    @(negedge mclk);
    check(32'(rx_enable), 32'h0, "powered down");
    check(32'(cfg), 32'(model), "config kept");
    reg_wr(REG_CTRL, 32'hE);
    repeat (WAKE + 10) @(posedge mclk);
    $display("test straps done");
    for (int g = 0; g < 2; g++) begin
      load(20'h08000 | 20'(g << BIT_GUARD), 19);
      toggles(30, t);
      check(32'(t), 32'h0, "asleep quiet");
      @(posedge mclk);
      rx_hit <= 1'b1;
      toggles(SLEEP + LISTEN + 40, t);
      check(32'(t > 0), 32'h1, "woken toggles");
      @(posedge mclk);
      rx_hit <= 1'b0;
      repeat (WATCH + 20) @(posedge mclk);
      toggles(20, t);
      check(32'(t > 0), 32'(g), "guard result");
    end
    load(20'h00000, 19);
    $display("test autopoll done");
    conclude();
  end
endmodule
